// ==== pic_primary_irq.v ====
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "pic_defines.vh"
// Summary of operation
// - edge register bits 3..2 pick pin b detection: off, rising, falling or both edges.
// - edge register bits 1..0 pick pin a detection with the same encoding.
// - unimplemented bits of all control registers read as zero.
// - control zero bit 0 is the global enable; when 0 no interrupt reaches the core.
// - control zero holds group0 flag bit 6, pin a flag bit 4, group0 enable bit 3, pin a enable bit 1.
// - control one holds flags timebase0 bit 7, converter bit 6, group2 bit 5, group1 bit 4.
// - control one holds enables timebase0 bit 3, converter bit 2, group2 bit 1, group1 bit 0.
// - control two holds pin b flag bit 5 and timebase1 flag bit 4.
// - control two holds pin b enable bit 1 and timebase1 enable bit 0; other bits unimplemented.
// - each source has an enable and a flag; the flag is set whatever the enable.
module pic_primary_irq (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        ext_pin_a,
  input  wire        ext_pin_b,
  input  wire        multi_group0_req,
  input  wire        multi_group1_req,
  input  wire        multi_group2_req,
  input  wire        timebase0_req,
  input  wire        timebase1_req,
  input  wire        converter_done_req,
  output wire        core_irq,
  output wire        bus_irq
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  reg  [7:0]  pin_edge_select_reg;
  reg  [7:0]  irq_control_zero_reg;
  reg  [7:0]  irq_control_one_reg;
  reg  [7:0]  irq_control_two_reg;
  reg  [2:0]  evt_stat_reg;
  reg  [2:0]  evt_ena_reg;
  reg         aw_hold_reg;
  reg  [7:0]  aw_addr_reg;
  reg         w_hold_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0]  w_strb_reg;
  wire        pin_a_hit;
  wire        pin_b_hit;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function [7:0] wr_ctl;
    input [7:0] new_val;
    input [7:0] mask;
    input [7:0] hw_set;
    begin
      wr_ctl = ((new_val & mask) | hw_set) & mask;
    end
  endfunction

  function [7:0] keep_ctl;
    input [7:0] old_val;
    input [7:0] mask;
    input [7:0] hw_set;
    begin
      keep_ctl = (old_val | hw_set) & mask;
    end
  endfunction

  // ----------------------------------------
  // pin edge detection
  // ----------------------------------------
  pic_edge_detect u_pin_a (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .pin_in   (ext_pin_a),
    .edge_sel (pin_edge_select_reg[1:0]),
    .edge_hit (pin_a_hit)
  );

  pic_edge_detect u_pin_b (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .pin_in   (ext_pin_b),
    .edge_sel (pin_edge_select_reg[3:2]),
    .edge_hit (pin_b_hit)
  );

  // ----------------------------------------
  // hardware flag sets
  // ----------------------------------------
  wire [7:0] set0 = {1'b0, multi_group0_req, 1'b0, pin_a_hit, 4'h0};
  wire [7:0] set1 = {timebase0_req, converter_done_req, multi_group2_req,
                     multi_group1_req, 4'h0};
  wire [7:0] set2 = {2'b00, pin_b_hit, timebase1_req, 4'h0};

  // ----------------------------------------
  // axi write channel
  // ----------------------------------------
  assign s_axi_awready = ~aw_hold_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold_reg & ~s_axi_bvalid;

  wire        aw_ok  = aw_hold_reg | (s_axi_awvalid & s_axi_awready);
  wire        w_ok   = w_hold_reg | (s_axi_wvalid & s_axi_wready);
  wire [7:0]  wa     = aw_hold_reg ? aw_addr_reg : s_axi_awaddr;
  wire [31:0] wd     = w_hold_reg ? w_data_reg : s_axi_wdata;
  wire [3:0]  ws     = w_hold_reg ? w_strb_reg : s_axi_wstrb;
  wire        do_wr  = aw_ok & w_ok & ~s_axi_bvalid;
  wire        lane0  = do_wr & ws[0];
  wire        wr_map = (wa == `PIC_ADDR_EDGE) || (wa == `PIC_ADDR_CTL0) || (wa == `PIC_ADDR_CTL1) ||
                       (wa == `PIC_ADDR_CTL2) || (wa == `PIC_ADDR_CLR) || (wa == `PIC_ADDR_ENA) ||
                       (wa == `PIC_ADDR_STAT);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg  <= 1'b0;
      aw_addr_reg  <= 8'h00;
      w_hold_reg   <= 1'b0;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PIC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready & ~do_wr) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_hold_reg <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready & ~do_wr) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (do_wr) begin
        w_hold_reg <= 1'b0;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? `PIC_RESP_OKAY : `PIC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_edge_select_reg  <= `PIC_RESET_VAL;
      irq_control_zero_reg <= `PIC_RESET_VAL;
      irq_control_one_reg  <= `PIC_RESET_VAL;
      irq_control_two_reg  <= `PIC_RESET_VAL;
    end else begin
      if (lane0 && wa == `PIC_ADDR_EDGE)
        pin_edge_select_reg <= wd[7:0] & `PIC_MASK_EDGE;
      // a source event in the write cycle survives a software clear
      if (lane0 && wa == `PIC_ADDR_CTL0)
        irq_control_zero_reg <= wr_ctl(wd[7:0], `PIC_MASK_CTL0, set0);
      else
        irq_control_zero_reg <= keep_ctl(irq_control_zero_reg, `PIC_MASK_CTL0, set0);
      if (lane0 && wa == `PIC_ADDR_CTL1)
        irq_control_one_reg <= wr_ctl(wd[7:0], `PIC_MASK_CTL1, set1);
      else
        irq_control_one_reg <= keep_ctl(irq_control_one_reg, `PIC_MASK_CTL1, set1);
      if (lane0 && wa == `PIC_ADDR_CTL2)
        irq_control_two_reg <= wr_ctl(wd[7:0], `PIC_MASK_CTL2, set2);
      else
        irq_control_two_reg <= keep_ctl(irq_control_two_reg, `PIC_MASK_CTL2, set2);
    end
  end

  // ----------------------------------------
  // interrupt gating to the core
  // ----------------------------------------
  wire [7:0] c0 = irq_control_zero_reg;
  wire [7:0] c1 = irq_control_one_reg;
  wire [7:0] c2 = irq_control_two_reg;

  wire any_src = (c0[`PIC_MG0_FLAG_BIT] & c0[`PIC_MG0_EN_BIT]) |
                 (c0[`PIC_PIN_A_FLAG_BIT] & c0[`PIC_PIN_A_EN_BIT]) |
                 (|(c1[7:4] & c1[3:0])) |
                 (c2[`PIC_PIN_B_FLAG_BIT] & c2[`PIC_PIN_B_EN_BIT]) |
                 (c2[`PIC_TB1_FLAG_BIT] & c2[`PIC_TB1_EN_BIT]);

  assign core_irq = c0[`PIC_GLOBAL_EN_BIT] & any_src;

  // ----------------------------------------
  // bus-side event status
  // ----------------------------------------
  wire [2:0] evt_now = {core_irq, pin_b_hit, pin_a_hit};
  wire       clr_wr  = lane0 && (wa == `PIC_ADDR_CLR);

  always @(posedge aclk) begin
    if (!aresetn) begin
      evt_stat_reg <= 3'b000;
      evt_ena_reg  <= 3'b000;
    end else begin
      evt_stat_reg <= (evt_stat_reg & ~(clr_wr ? wd[2:0] : 3'b000)) | evt_now;
      if (lane0 && wa == `PIC_ADDR_ENA)
        evt_ena_reg <= wd[2:0];
    end
  end

  assign bus_irq = |(evt_stat_reg & evt_ena_reg);

  // ----------------------------------------
  // axi read channel
  // ----------------------------------------
  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `PIC_RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `PIC_RESP_OKAY;
      if (s_axi_araddr == `PIC_ADDR_EDGE)
        s_axi_rdata <= {24'h000000, pin_edge_select_reg};
      else if (s_axi_araddr == `PIC_ADDR_CTL0)
        s_axi_rdata <= {24'h000000, irq_control_zero_reg};
      else if (s_axi_araddr == `PIC_ADDR_CTL1)
        s_axi_rdata <= {24'h000000, irq_control_one_reg};
      else if (s_axi_araddr == `PIC_ADDR_CTL2)
        s_axi_rdata <= {24'h000000, irq_control_two_reg};
      else if (s_axi_araddr == `PIC_ADDR_STAT)
        s_axi_rdata <= {29'h0, evt_stat_reg};
      else if (s_axi_araddr == `PIC_ADDR_ENA)
        s_axi_rdata <= {29'h0, evt_ena_reg};
      else if (s_axi_araddr == `PIC_ADDR_CLR)
        s_axi_rdata <= 32'h0000_0000;
      else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `PIC_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ==== pic_defines.vh ====
`ifndef PIC_DEFINES_VH
`define PIC_DEFINES_VH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define PIC_ADDR_EDGE      8'h00
`define PIC_ADDR_CTL0      8'h04
`define PIC_ADDR_CTL1      8'h08
`define PIC_ADDR_CTL2      8'h0c
`define PIC_ADDR_STAT      8'h10
`define PIC_ADDR_CLR       8'h14
`define PIC_ADDR_ENA       8'h18
// ----------------------------------------
// implemented-bit masks
// ----------------------------------------
`define PIC_MASK_EDGE      8'h0f
`define PIC_MASK_CTL0      8'h5b
`define PIC_MASK_CTL1      8'hff
`define PIC_MASK_CTL2      8'h33
`define PIC_RESET_VAL      8'h00
// ----------------------------------------
// field positions
// ----------------------------------------
`define PIC_GLOBAL_EN_BIT  0
`define PIC_PIN_A_EN_BIT   1
`define PIC_MG0_EN_BIT     3
`define PIC_PIN_A_FLAG_BIT 4
`define PIC_MG0_FLAG_BIT   6
`define PIC_PIN_B_EN_BIT   1
`define PIC_TB1_EN_BIT     0
`define PIC_PIN_B_FLAG_BIT 5
`define PIC_TB1_FLAG_BIT   4
// ----------------------------------------
// edge select encoding
// ----------------------------------------
`define PIC_EDGE_OFF       2'b00
`define PIC_EDGE_RISE      2'b01
`define PIC_EDGE_FALL      2'b10
`define PIC_EDGE_BOTH      2'b11
// ----------------------------------------
// axi responses
// ----------------------------------------
`define PIC_RESP_OKAY      2'b00
`define PIC_RESP_SLVERR    2'b10
`endif

// ==== pic_edge_detect.v ====
`timescale 1ns/1ps
`include "pic_defines.vh"
// ----------------------------------------
// pin synchroniser and edge detector
// ----------------------------------------
module pic_edge_detect (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       pin_in,
  input  wire [1:0] edge_sel,
  output wire       edge_hit
);
  reg sync1_reg;
  reg sync2_reg;
  reg last_reg;

  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      last_reg  <= 1'b0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      last_reg  <= sync2_reg;
    end
  end

  wire rise = sync2_reg & ~last_reg;
  wire fall = ~sync2_reg & last_reg;

  assign edge_hit = (edge_sel == `PIC_EDGE_RISE) ? rise :
                    (edge_sel == `PIC_EDGE_FALL) ? fall :
                    (edge_sel == `PIC_EDGE_BOTH) ? (rise | fall) : 1'b0;
endmodule

// ==== pic_primary_irq_props.sv ====
`timescale 1ns/1ps
module pic_primary_irq_props (
  input wire        aclk,
  input wire        aresetn,
  input wire [7:0]  s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [7:0]  s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        core_irq,
  input wire        bus_irq
);
  logic gie_reg;
  logic wr_hs;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  assign wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  // shadow of the global enable, tracked from bus writes
  always @(posedge aclk) begin
    if (!aresetn) gie_reg <= 1'b0;
    else if (wr_hs && s_axi_awaddr == 8'h04) gie_reg <= s_axi_wdata[0];
  end
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_lat: assert property (wr_hs |=> s_axi_bvalid)
    else $error("write answer late");
  a_ar_gate: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready not inverse of rvalid");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_global_gate: assert property (!gie_reg |-> !core_irq)
    else $error("core irq with global enable off");
  a_reset_clear: assert property ($rose(aresetn) |-> !core_irq && !bus_irq)
    else $error("irq high after reset");
  a_unmapped_rd: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h20
    |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  c_core: cover property (core_irq);
  c_bus: cover property (bus_irq);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule
bind pic_primary_irq pic_primary_irq_props props (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .core_irq, .bus_irq
);

// ==== pic_src_model.sv ====
`timescale 1ns/1ps
// sources: 0 group0, 1 group1, 2 group2, 3 timebase0, 4 converter, 5 timebase1
module pic_src_model (
  input  wire       aclk,
  output reg  [5:0] req,
  output reg  [1:0] pin
);
  initial begin
    req = 6'h00;
    pin = 2'b00;
  end
  task pulse(input int i);
    begin
      @(posedge aclk) req[i] <= 1'b1;
      @(posedge aclk) req[i] <= 1'b0;
    end
  endtask
  task drive_pin(input int i, input logic v);
    begin
      @(posedge aclk) pin[i] <= v;
    end
  endtask
endmodule

// ==== tb_primary_interrupt_control.sv ====
`timescale 1ns/1ps
module tb_primary_interrupt_control;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, core_irq, bus_irq;
  wire [1:0]   s_axi_bresp, s_axi_rresp, pin;
  wire [31:0]  s_axi_rdata;
  wire [5:0]   req;
  logic [31:0] rv;
  logic [1:0]  rr;
  int          bad_count = 0, n_compared = 0;
  int          rdy_lag = 0;
  localparam logic [7:0] mask_tab [4] = '{8'h0f, 8'h5b, 8'hff, 8'h33};
  localparam logic [7:0] src_addr [6] = '{8'h04, 8'h08, 8'h08, 8'h08, 8'h08, 8'h0c};
  localparam int         src_flag [6] = '{6, 4, 5, 7, 6, 4};
  localparam int         src_en [6]   = '{3, 0, 1, 3, 2, 0};
  pic_primary_irq dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ext_pin_a(pin[0]), .ext_pin_b(pin[1]), .multi_group0_req(req[0]), .multi_group1_req(req[1]),
    .multi_group2_req(req[2]), .timebase0_req(req[3]), .converter_done_req(req[4]),
    .timebase1_req(req[5]), .core_irq, .bus_irq
  );
  pic_src_model src (.aclk, .req, .pin);
  initial begin
    forever #2 aclk = ~aclk;
  end
  task test_done;
    begin
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    begin
      n_compared++;
      if (got !== exp) begin
        bad_count++;
        $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic aw_done, w_done;
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= (rdy_lag == 0);
      aw_done = 1'b0;
      w_done = 1'b0;
      n = 0;
      // each channel is released at the edge that takes it
      do begin
        @(posedge aclk);
        n++;
        if (!aw_done && s_axi_awready) begin
          aw_done = 1'b1;
          s_axi_awvalid <= 1'b0;
        end
        if (!w_done && s_axi_wready) begin
          w_done = 1'b1;
          s_axi_wvalid <= 1'b0;
        end
      end while (!(aw_done && w_done) && n < 50);
      repeat (rdy_lag) @(posedge aclk);
      s_axi_bready <= 1'b1;
      do begin @(posedge aclk); n++; end while (!(s_axi_bvalid && s_axi_bready) && n < 50);
      s_axi_bready <= 1'b0;
      r = s_axi_bresp;
      if (n >= 50) begin
        bad_count++;
        test_done;
      end
    end
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= (rdy_lag == 0);
      n = 0;
      do begin @(posedge aclk); n++; end while (!s_axi_arready && n < 50);
      s_axi_arvalid <= 1'b0;
      repeat (rdy_lag) @(posedge aclk);
      s_axi_rready <= 1'b1;
      do begin @(posedge aclk); n++; end while (!(s_axi_rvalid && s_axi_rready) && n < 50);
      s_axi_rready <= 1'b0;
      d = s_axi_rdata;
      r = s_axi_rresp;
      if (n >= 50) begin
        bad_count++;
        test_done;
      end
    end
  endtask
  task t_regs;
    begin
      // late ready: the answer must stand until it is taken
      rdy_lag = 2;
      for (int i = 0; i < 4; i++) begin
        rd(8'(4 * i), rv, rr);
        chk("reset value", 32'h0, rv);
        wr(8'(4 * i), 32'hffff_ffff, rr);
        rd(8'(4 * i), rv, rr);
        chk("masked readback", {24'h0, mask_tab[i]}, rv);
        wr(8'(4 * i), 32'h0, rr);
      end
      rdy_lag = 0;
      wr(8'h20, 32'h1, rr);
      chk("unmapped write resp", 32'h2, 32'(rr));
      rd(8'h20, rv, rr);
      chk("unmapped read resp", 32'h2, 32'(rr));
      $display("t_regs done");
    end
  endtask
  task t_pin;
    logic [7:0] a, fb;
    logic [1:0] m;
    begin
      for (int p = 0; p < 2; p++) begin
        for (int k = 0; k < 4; k++) begin
          a = p ? 8'h0c : 8'h04;
          fb = p ? 8'h20 : 8'h10;
          m = k[1:0];
          wr(8'h00, {28'h0, p ? {m, 2'b00} : {2'b00, m}}, rr);
          src.drive_pin(p, 1'b1);
          repeat (5) @(posedge aclk);
          rd(a, rv, rr);
          chk("flag after rise", {24'h0, m[0] ? fb : 8'h00}, rv);
          wr(a, 32'h0, rr);
          src.drive_pin(p, 1'b0);
          repeat (5) @(posedge aclk);
          rd(a, rv, rr);
          chk("flag after fall", {24'h0, m[1] ? fb : 8'h00}, rv);
          wr(a, 32'h0, rr);
        end
      end
      $display("t_pin done");
    end
  endtask
  task t_src;
    logic [7:0] f, e, g;
    begin
      for (int i = 0; i < 6; i++) begin
        f = 8'h01 << src_flag[i];
        e = 8'h01 << src_en[i];
        g = (i == 0) ? 8'h01 : 8'h00;
        src.pulse(i);
        rd(src_addr[i], rv, rr);
        chk("flag with enable off", {24'h0, f}, rv);
        wr(src_addr[i], {24'h0, f | e}, rr);
        chk("irq with global off", 32'h0, 32'(core_irq));
        wr(8'h04, {24'h0, (i == 0 ? f | e : 8'h00) | 8'h01}, rr);
        chk("irq all enabled", 32'h1, 32'(core_irq));
        wr(src_addr[i], {24'h0, e | g}, rr);
        chk("irq after flag clear", 32'h0, 32'(core_irq));
        wr(src_addr[i], 32'h0, rr);
        wr(8'h04, 32'h0, rr);
      end
      $display("t_src done");
    end
  endtask
  task t_event;
    begin
      // drop status left over from earlier tests
      wr(8'h14, 32'h7, rr);
      rd(8'h10, rv, rr);
      chk("event status cleared", 32'h0, rv);
      wr(8'h18, 32'h1, rr);
      chk("bus irq idle", 32'h0, 32'(bus_irq));
      wr(8'h00, 32'h1, rr);
      src.drive_pin(0, 1'b1);
      repeat (5) @(posedge aclk);
      chk("bus irq raised", 32'h1, 32'(bus_irq));
      rd(8'h10, rv, rr);
      chk("event status", 32'h1, rv);
      wr(8'h18, 32'h0, rr);
      chk("bus irq masked", 32'h0, 32'(bus_irq));
      wr(8'h14, 32'h1, rr);
      wr(8'h18, 32'h1, rr);
      chk("bus irq cleared", 32'h0, 32'(bus_irq));
      $display("t_event done");
    end
  endtask
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_pin;
    t_src;
    t_event;
    test_done;
  end
endmodule
